// *** idsp_pkg.sv ***
// Package: constants for the bus status and poll block
package idsp_pkg;
  localparam int NumCond = 10;
  localparam int BitFault = 0;
  localparam int BitReady = 4;
  localparam int BitError = 5;
  localparam int BitRqs = 6;
  localparam int BitPwrOn = 7;
  localparam int CondErr = 6;
  localparam logic [7:0] StatusReset = 8'h80;
  localparam logic [9:0] MaskReset = 10'h000;
  localparam int SyncStages = 3;
endpackage

// *** idsp_status_poll.sv ***
// Module: device-side bus status, polling, clear/trigger and remote logic
//
// Behaviour
// - Provide talker, listener, clear, trigger, poll, remote and request functions.
// - Addressed indicator is on while addressed as listener or talker.
// - Device Clear resets status, faults, mask, request and pending trigger in local or remote.
// - Device Trigger applies values held pending since the hold command.
// - Trigger in local mode is deferred until going from local to remote.
// - Parallel-poll response bit follows status byte bit 7.
// - Parallel poll leaves request and request-service bit unchanged.
// - Remote enable plus lockout ignores front-panel local switch; release of remote enable drops remote and lockout.
// - Service request asserted at power-on and on any enabled fault of ten.
// - Power-on request switch is recorded at start-up in the separate power-on flag, not in the fault register.
// - Source masking affects only service request, not condition state or indicators.
// - Serial poll returns eight-bit status byte; bits 1 to 3 unused.
// - Bit 0 set by any new fault bit, cleared by fault query.
// - Bit 4 set while ready, held clear during command processing.
// - Bit 5 set by status error bit, cleared by error query.
// - Bit 6 set while requesting service, cleared by serial poll.
// - Bit 7 set at power-on init, cleared by clear command or Device Clear.
`timescale 1ns/1ps
`default_nettype none
module idsp_status_poll #(
  parameter int NumCond = idsp_pkg::NumCond
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic listenAddr,
  input wire logic talkAddr,
  input wire logic devClear,
  input wire logic devTrigger,
  input wire logic initStateCmd,
  input wire logic holdCmd,
  input wire logic faultQuery,
  input wire logic errorQuery,
  input wire logic serialPoll,
  input wire logic parallelPoll,
  input wire logic cmdBusy,
  input wire logic remoteEnable,
  input wire logic localLockout,
  input wire logic goRemote,
  input wire logic localSwitch,
  input wire logic powerOnRequestSwitch,
  input wire logic [NumCond-1:0] condIn,
  input wire logic [NumCond-1:0] maskWrData,
  input wire logic maskWrEn,
  input wire logic ppConfigWr,
  input wire logic [2:0] ppLineIn,
  input wire logic ppSenseIn,
  output logic addressed,
  output logic remoteMode,
  output logic srqOut,
  output logic [7:0] pollStatusByte,
  output logic [7:0] ppDio,
  output logic applyHeld,
  output logic initPulse,
  output logic powerOnFlag,
  output logic [NumCond-1:0] faultReg,
  output logic [NumCond-1:0] condIndicator
);
  typedef struct packed {
    logic [idsp_pkg::SyncStages-1:0] swSync;
    logic swStable;
    logic [NumCond-1:0] condPrev;
    logic [NumCond-1:0] fault;
    logic [NumCond-1:0] mask;
    logic [NumCond-1:0] ind;
    logic [7:0] status;
    logic pwrFlag;
    logic remote;
    logic lockout;
    logic holdPending;
    logic trigDeferred;
    logic apply;
    logic initP;
    logic addr;
    logic srq;
    logic [7:0] pp;
    logic ppConfigured;
    logic [2:0] ppLine;
    logic ppSense;
    logic started;
  } idsp_state_t;

  idsp_state_t st_ff;
  idsp_state_t nxt_st;
  logic [NumCond-1:0] newFault;
  logic goRem;

  always_comb begin
    nxt_st = st_ff;
    newFault = '0;
    goRem = 1'b0;
    nxt_st.swSync = {st_ff.swSync[idsp_pkg::SyncStages-2:0], localSwitch};
    // Front-panel switch counts once stages two and three agree
    if (st_ff.swSync[1] == st_ff.swSync[2]) begin
      nxt_st.swStable = st_ff.swSync[2];
    end
    nxt_st.apply = 1'b0;
    nxt_st.initP = 1'b0;
    nxt_st.started = 1'b1;
    nxt_st.addr = listenAddr | talkAddr;
    nxt_st.ind = condIn;
    nxt_st.condPrev = condIn;
    // Release of remote enable drops lockout and returns to local
    if (!remoteEnable) begin
      nxt_st.lockout = 1'b0;
      nxt_st.remote = 1'b0;
    end else begin
      if (localLockout) begin
        nxt_st.lockout = 1'b1;
      end
      if (goRemote && !st_ff.remote) begin
        nxt_st.remote = 1'b1;
        goRem = 1'b1;
      end else if (st_ff.swStable && !st_ff.lockout && !localLockout) begin
        nxt_st.remote = 1'b0;
      end
    end
    if (maskWrEn) begin
      nxt_st.mask = maskWrData;
    end
    if (ppConfigWr) begin
      nxt_st.ppConfigured = 1'b1;
      nxt_st.ppLine = ppLineIn;
      nxt_st.ppSense = ppSenseIn;
    end
    if (holdCmd) begin
      nxt_st.holdPending = 1'b1;
    end
    // Trigger while local waits for the local-to-remote edge
    if (devTrigger && st_ff.holdPending) begin
      if (st_ff.remote) begin
        nxt_st.apply = 1'b1;
        nxt_st.holdPending = 1'b0;
      end else begin
        nxt_st.trigDeferred = 1'b1;
      end
    end
    if (goRem && st_ff.trigDeferred) begin
      nxt_st.apply = 1'b1;
      nxt_st.trigDeferred = 1'b0;
      nxt_st.holdPending = 1'b0;
    end
    // Clears first so that a same-cycle set wins
    if (faultQuery) begin
      nxt_st.status[idsp_pkg::BitFault] = 1'b0;
      nxt_st.fault = '0;
    end
    if (errorQuery) begin
      nxt_st.status[idsp_pkg::BitError] = 1'b0;
    end
    if (serialPoll) begin
      nxt_st.status[idsp_pkg::BitRqs] = 1'b0;
      nxt_st.srq = 1'b0;
    end
    if (initStateCmd) begin
      nxt_st.status[idsp_pkg::BitPwrOn] = 1'b0;
      nxt_st.pwrFlag = 1'b0;
      nxt_st.initP = 1'b1;
    end
    newFault = condIn & ~st_ff.condPrev;
    nxt_st.fault = nxt_st.fault | newFault;
    if (|newFault) begin
      nxt_st.status[idsp_pkg::BitFault] = 1'b1;
    end
    if (newFault[idsp_pkg::CondErr]) begin
      nxt_st.status[idsp_pkg::BitError] = 1'b1;
    end
    // Masked sources still latch in the fault register
    if (|(newFault & st_ff.mask)) begin
      nxt_st.srq = 1'b1;
      nxt_st.status[idsp_pkg::BitRqs] = 1'b1;
    end
    nxt_st.status[idsp_pkg::BitReady] = ~cmdBusy;
    nxt_st.status[3:1] = 3'h0;
    // Device Clear resets status, faults, mask, hold and request, remote or local; remote state and poll setup are kept
    if (devClear) begin
      nxt_st.status = idsp_pkg::StatusReset;
      nxt_st.status[idsp_pkg::BitPwrOn] = 1'b0;
      nxt_st.status[idsp_pkg::BitReady] = ~cmdBusy;
      nxt_st.holdPending = 1'b0;
      nxt_st.trigDeferred = 1'b0;
      nxt_st.fault = '0;
      nxt_st.pwrFlag = 1'b0;
      nxt_st.srq = 1'b0;
      nxt_st.mask = idsp_pkg::MaskReset;
      nxt_st.initP = 1'b1;
    end
    // Parallel poll only reads; it never touches request state
    nxt_st.pp = 8'h00;
    if (parallelPoll && st_ff.ppConfigured) begin
      nxt_st.pp[st_ff.ppLine] = (st_ff.status[idsp_pkg::BitPwrOn] == st_ff.ppSense);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.status <= idsp_pkg::StatusReset;
      st_ff.srq <= 1'b1;
      st_ff.mask <= idsp_pkg::MaskReset;
    end else if (!st_ff.started) begin
      st_ff <= nxt_st;
      st_ff.status[idsp_pkg::BitRqs] <= 1'b1;
      st_ff.status[idsp_pkg::BitPwrOn] <= 1'b1;
      st_ff.srq <= 1'b1;
      st_ff.pwrFlag <= powerOnRequestSwitch;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign addressed = st_ff.addr;
  assign remoteMode = st_ff.remote;
  assign srqOut = st_ff.srq;
  assign pollStatusByte = st_ff.status;
  assign ppDio = st_ff.pp;
  assign applyHeld = st_ff.apply;
  assign initPulse = st_ff.initP;
  assign powerOnFlag = st_ff.pwrFlag;
  assign faultReg = st_ff.fault;
  assign condIndicator = st_ff.ind;

  addr_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    1 |=> addressed == $past(listenAddr | talkAddr))
    else $error("addressed wrong");

  clear_pwron_a: assert property (@(posedge clk) disable iff (!nrst)
    devClear && st_ff.started |=> !pollStatusByte[7] && !srqOut)
    else $error("clear failed");

  trig_apply_a: assert property (@(posedge clk) disable iff (!nrst)
    applyHeld |-> $past(remoteMode) || remoteMode)
    else $error("apply while local");

  unused_bits_a: assert property (@(posedge clk) disable iff (!nrst)
    pollStatusByte[3:1] == 3'h0)
    else $error("unused bits set");

  ready_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(cmdBusy) && st_ff.started |-> !pollStatusByte[4])
    else $error("ready during busy");

  poll_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    serialPoll && !(|(condIn & ~st_ff.condPrev & st_ff.mask)) && st_ff.started
    |=> !pollStatusByte[6]) else $error("poll clear failed");

  fault_set_a: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.started && |(condIn & ~st_ff.condPrev) && !devClear |=> pollStatusByte[0])
    else $error("fault bit not set");

  indicator_a: assert property (@(posedge clk) disable iff (!nrst)
    maskWrEn |=> condIndicator == $past(condIn))
    else $error("indicator disturbed");

  lockout_a: assert property (@(posedge clk) disable iff (!nrst)
    remoteMode && st_ff.lockout && remoteEnable |=> remoteMode)
    else $error("lockout lost");

  pp_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    parallelPoll && st_ff.ppConfigured && !ppConfigWr
    |=> ppDio[st_ff.ppLine] == ($past(pollStatusByte[7]) == st_ff.ppSense)) else $error("poll bit wrong");

  pp_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !parallelPoll |=> ppDio == 8'h00)
    else $error("poll lines driven while idle");

  pp_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    parallelPoll && !serialPoll && !devClear && srqOut |=> srqOut && pollStatusByte[6])
    else $error("parallel poll dropped request");

  srq_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.started |-> srqOut == pollStatusByte[6])
    else $error("request bit and line differ");

  trig_refused_a: assert property (@(posedge clk) disable iff (!nrst)
    devTrigger && !remoteMode && !goRemote |=> !applyHeld)
    else $error("local trigger applied");

  trig_now_a: assert property (@(posedge clk) disable iff (!nrst)
    devTrigger && st_ff.holdPending && remoteMode |=> applyHeld)
    else $error("trigger not applied");

  defer_apply_a: assert property (@(posedge clk) disable iff (!nrst)
    goRemote && remoteEnable && !remoteMode && st_ff.trigDeferred |=> applyHeld && remoteMode)
    else $error("deferred trigger lost");

  init_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    devClear |=> initPulse)
    else $error("clear did not reinitialise");

  init_cmd_a: assert property (@(posedge clk) disable iff (!nrst)
    initStateCmd && st_ff.started |=> !pollStatusByte[7] && !powerOnFlag && initPulse)
    else $error("init command failed");

  clear_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    devClear |=> faultReg == '0 && st_ff.mask == idsp_pkg::MaskReset)
    else $error("clear left faults or mask");

  pwr_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    !st_ff.started |=> powerOnFlag == $past(powerOnRequestSwitch))
    else $error("power-on flag wrong");

  pwr_srq_a: assert property (@(posedge clk) disable iff (!nrst)
    !st_ff.started |=> srqOut && pollStatusByte[7] && pollStatusByte[6])
    else $error("no power-on request");

  fault_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    pollStatusByte[0] && !faultQuery && !devClear |=> pollStatusByte[0])
    else $error("fault bit lost");

  err_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    pollStatusByte[5] && !errorQuery && !devClear |=> pollStatusByte[5])
    else $error("error bit lost");

  rqs_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    pollStatusByte[6] && !serialPoll && !devClear |=> pollStatusByte[6])
    else $error("request bit lost");

  pon_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    pollStatusByte[7] && !initStateCmd && !devClear |=> pollStatusByte[7])
    else $error("power-on bit lost");

  fault_reg_a: assert property (@(posedge clk) disable iff (!nrst)
    !faultQuery && !devClear |=> (faultReg & $past(faultReg)) == $past(faultReg))
    else $error("fault register bit lost");

  fault_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    faultQuery && !(|(condIn & ~st_ff.condPrev)) |=> !pollStatusByte[0] && faultReg == '0)
    else $error("fault query did not clear");

  err_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    errorQuery && !(condIn[idsp_pkg::CondErr] && !st_ff.condPrev[idsp_pkg::CondErr])
    |=> !pollStatusByte[5]) else $error("error query did not clear");

  err_set_a: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.started && condIn[idsp_pkg::CondErr] && !st_ff.condPrev[idsp_pkg::CondErr]
    && !devClear |=> pollStatusByte[5]) else $error("error bit not set");

  mask_srq_a: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.started && |(condIn & ~st_ff.condPrev & st_ff.mask) && !devClear |=> srqOut)
    else $error("enabled fault gave no request");

  masked_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.started && !(|(condIn & ~st_ff.condPrev & st_ff.mask)) && !srqOut |=> !srqOut)
    else $error("masked fault raised request");

  local_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    !remoteEnable |=> !remoteMode && !st_ff.lockout)
    else $error("remote kept without enable");

  ready_free_a: assert property (@(posedge clk) disable iff (!nrst)
    !cmdBusy && st_ff.started |=> pollStatusByte[4])
    else $error("ready missing while idle");
endmodule
`default_nettype wire

// *** idsp_ctrl_model.sv ***
// Controller-side model issuing one-cycle interface requests
`timescale 1ns/1ps
`default_nettype none
module idsp_ctrl_model (
  input wire logic clk,
  output logic [10:0] cmd,
  output logic [2:0] ppLine,
  output logic ppSense,
  output logic [9:0] maskData
);
  initial begin
    cmd = 11'h000;
    ppLine = 3'h0;
    ppSense = 1'b0;
    maskData = 10'h000;
  end
  // Data is qualified only by its strobe, so it is scrambled once released
  task automatic req(input int idx, input logic [2:0] ln, input logic sn,
                     input logic [9:0] md);
    @(posedge clk);
    cmd[idx] <= 1'b1;
    ppLine <= ln;
    ppSense <= sn;
    maskData <= md;
    @(posedge clk);
    cmd[idx] <= 1'b0;
    ppLine <= ~ln;
    ppSense <= ~sn;
    maskData <= ~md;
  endtask
endmodule
`default_nettype wire

// *** test_idsp_status_poll.sv ***
// Self-checking bench for the bus status and poll block
`timescale 1ns/1ps
`default_nettype none
module test_idsp_status_poll;
  logic clk = 1'b0, nrst = 1'b0, listenAddr = 1'b0, talkAddr = 1'b0, parallelPoll = 1'b0;
  logic cmdBusy = 1'b0, remoteEnable = 1'b0, localSwitch = 1'b0, pwrSw = 1'b1;
  logic [9:0] condIn = 10'h000;
  logic addressed, remoteMode, srqOut, applyHeld, initPulse, powerOnFlag;
  logic [7:0] stat, ppDio;
  logic [9:0] faultReg, condIndicator, maskData;
  logic [10:0] cmd;
  logic [2:0] ppLine;
  logic ppSense;
  int miscompares = 0, comparisons = 0, applies = 0, cycles = 0, inits = 0;
  idsp_ctrl_model i_idsp_ctrl_model (.clk(clk), .cmd(cmd), .ppLine(ppLine),
    .ppSense(ppSense), .maskData(maskData));
  idsp_status_poll i_idsp_status_poll (.clk(clk), .nrst(nrst), .listenAddr(listenAddr),
    .talkAddr(talkAddr), .devClear(cmd[0]), .devTrigger(cmd[1]), .initStateCmd(cmd[2]),
    .holdCmd(cmd[3]), .faultQuery(cmd[4]), .errorQuery(cmd[5]), .serialPoll(cmd[6]),
    .parallelPoll(parallelPoll), .cmdBusy(cmdBusy), .remoteEnable(remoteEnable),
    .localLockout(cmd[7]), .goRemote(cmd[8]), .localSwitch(localSwitch),
    .powerOnRequestSwitch(pwrSw), .condIn(condIn), .maskWrData(maskData),
    .maskWrEn(cmd[10]), .ppConfigWr(cmd[9]), .ppLineIn(ppLine), .ppSenseIn(ppSense),
    .addressed(addressed), .remoteMode(remoteMode), .srqOut(srqOut),
    .pollStatusByte(stat), .ppDio(ppDio), .applyHeld(applyHeld), .initPulse(initPulse),
    .powerOnFlag(powerOnFlag), .faultReg(faultReg), .condIndicator(condIndicator));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (applyHeld === 1'b1) applies++;
    if (initPulse === 1'b1) inits++;
    // Whole sequence needs well under a thousand cycles
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rq(input int idx);
    i_idsp_ctrl_model.req(idx, 3'h0, 1'b0, 10'h000);
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    chk(stat, 8'hd0);
    chk({7'h00, srqOut & powerOnFlag}, 8'h01);
    rq(6);
    tick(1);
    chk(stat, 8'h90);
    @(posedge clk);
    cmdBusy <= 1'b1;
    tick(2);
    chk(stat, 8'h80);
    @(posedge clk);
    cmdBusy <= 1'b0;
    i_idsp_ctrl_model.req(9, 3'h2, 1'b1, 10'h000);
    @(posedge clk);
    parallelPoll <= 1'b1;
    tick(2);
    chk(ppDio, 8'h04);
    chk(stat, 8'h90);
    @(posedge clk);
    parallelPoll <= 1'b0;
    $display("status and poll tests done");
    i_idsp_ctrl_model.req(10, 3'h0, 1'b0, 10'h041);
    @(posedge clk);
    condIn <= 10'h003;
    tick(2);
    chk(stat, 8'hd1);
    chk(condIndicator[7:0], 8'h03);
    chk(faultReg[7:0], 8'h03);
    @(posedge clk);
    parallelPoll <= 1'b1;
    tick(2);
    chk(stat, 8'hd1);
    chk({7'h00, srqOut}, 8'h01);
    @(posedge clk);
    parallelPoll <= 1'b0;
    @(posedge clk);
    condIn <= 10'h043;
    tick(2);
    chk(stat, 8'hf1);
    chk(faultReg[7:0], 8'h43);
    rq(5);
    tick(1);
    chk(stat, 8'hd1);
    rq(4);
    rq(6);
    tick(1);
    chk(stat, 8'h90);
    chk(faultReg[7:0], 8'h00);
    rq(0);
    tick(1);
    chk({7'h00, stat[7]}, 8'h00);
    chk(inits[7:0], 8'h01);
    @(posedge clk);
    parallelPoll <= 1'b1;
    tick(2);
    chk(ppDio, 8'h00);
    @(posedge clk);
    parallelPoll <= 1'b0;
    rq(2);
    tick(1);
    chk(inits[7:0], 8'h02);
    $display("fault and clear tests done");
    @(posedge clk);
    remoteEnable <= 1'b1;
    rq(8);
    rq(3);
    rq(1);
    tick(2);
    chk(applies[7:0], 8'h01);
    @(posedge clk);
    localSwitch <= 1'b1;
    tick(8);
    chk({7'h00, remoteMode}, 8'h00);
    @(posedge clk);
    localSwitch <= 1'b0;
    rq(3);
    rq(1);
    tick(3);
    chk(applies[7:0], 8'h01);
    rq(8);
    tick(2);
    chk(applies[7:0], 8'h02);
    rq(7);
    @(posedge clk);
    localSwitch <= 1'b1;
    tick(8);
    chk({7'h00, remoteMode}, 8'h01);
    @(posedge clk);
    remoteEnable <= 1'b0;
    tick(8);
    chk({7'h00, remoteMode}, 8'h00);
    @(posedge clk);
    listenAddr <= 1'b1;
    tick(2);
    chk({7'h00, addressed}, 8'h01);
    @(posedge clk);
    listenAddr <= 1'b0;
    talkAddr <= 1'b1;
    tick(2);
    chk({7'h00, addressed}, 8'h01);
    @(posedge clk);
    talkAddr <= 1'b0;
    tick(2);
    chk({7'h00, addressed}, 8'h00);
    $display("trigger, remote and address tests done");
    results();
  end
endmodule
`default_nettype wire
